// [ffmlmd_bench.sv]
// Purpose: self-checking bench of the fp decode block
// Assumes: pipeline model masters the register bus
// Notes:   reads note expectations; a monitor compares in data phase

`timescale 1ns/1ps

module ffmlmd_bench;
  import ffmlmd_pkg::*;
  logic        CLOCK, SRST, HSEL, HWRITE, HREADYOUT, HRESP, TRAP;
  logic [31:0] HADDR, HWDATA, HRDATA, b, v, w, junk;
  logic [1:0]  HTRANS;
  logic [2:0]  HSIZE;
  logic        rd_dp = 1'b0;
  logic [31:0] expq [$];
  int          n_mismatch = 0;
  int          total_checks = 0;
  logic [31:0] fsrc [5] = '{32'hBFC0_0000, 32'h4020_0000, 32'hCF00_0000,
                            32'h4F00_0000, 32'h7FC0_0000};
  logic [31:0] fexp [5] = '{32'hFFFF_FFFE, 32'h0000_0002, 32'h8000_0000,
                            32'h7FFF_FFFF, 32'h7FFF_FFFF};

  ffmlmd_top uut (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
    .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
    .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
    .HRESP(HRESP), .TRAP(TRAP));
  ffmlmd_cpu_model cpu (.CLOCK(CLOCK), .HRDATA(HRDATA), .HREADY(HREADYOUT),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA));

  // ==========================================================
  // clock, 50 ns period
  initial begin
    CLOCK = 1'b0;
    forever #25 CLOCK = ~CLOCK;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t read %h expected %h", $time, seen, exp);
    end
  endtask

  // monitor: oldest note against each read data phase
  always @(posedge CLOCK) begin
    if (rd_dp) chk(HRDATA, expq.pop_front());
    rd_dp = HSEL && HREADYOUT && HTRANS[1] && !HWRITE;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    cpu.xfer(1'b1, a, d, junk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    expq.push_back(e);
    cpu.xfer(1'b0, a, 32'h0, junk);
  endtask
  task automatic ex(input logic [31:0] i);
    wr(A_INSTR, i);
  endtask
  function automatic logic [31:0] cop(input logic [4:0] f, t, s, d,
                                      input logic [5:0] fn);
    return {OP_FP_COPROCESSOR_MAJOR_OPCODE, f, t, s, d, fn};
  endfunction
  // move-in is deferred, so a filler issue commits it
  task automatic put(input logic [4:0] r, input logic [31:0] d);
    wr(A_GPR, d);
    ex(cop(RS_MT, 5'h0, r, 5'h0, 6'h0));
    ex(cop(RS_MF, 5'h0, 5'h1F, 5'h0, 6'h0));
  endtask
  task automatic fpr(input logic [4:0] r, input logic [7:0] a,
                     input logic [31:0] e);
    wr(A_FSEL, {27'h0, r});
    rd(a, e);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // ==========================================================
  // watchdog, far beyond the hundred or so transfers run
  initial begin
    repeat (20000) @(posedge CLOCK);
    n_mismatch++;
    give_verdict();
  end

  // main sequence
  initial begin
    junk = $urandom(32'h46E4);
    SRST = 1'b1;
    repeat (4) @(posedge CLOCK);
    SRST <= 1'b0;
    rd(A_CTRL, 32'h0);
    rd(A_STATUS, 32'h0);
    wr(8'h3C, 32'hFFFF_FFFF);
    rd(8'h3C, 32'h0);
    wr(A_CTRL, 32'hF);
    rd(A_CTRL, 32'hF);
    $display("done: registers");
    // round toward zero selected, floor must ignore it
    wr(A_CTRL, 32'h3);
    foreach (fsrc[i]) begin
      put(5'h2, fsrc[i]);
      ex(cop(FMT_S, 5'h0, 5'h2, 5'h3, FN_FLOOR_W));
      fpr(5'h3, A_FPR_LO, fexp[i]);
    end
    rd(A_STATUS, 32'h40);
    wr(A_CTRL, 32'h9);
    ex(cop(FMT_S, 5'h0, 5'h2, 5'h4, FN_FLOOR_W));
    rd(A_STATUS, 32'h44);
    fpr(5'h4, A_FPR_LO, 32'h0);
    ex(cop(FMT_S, 5'h0, 5'h2, 5'h4, FN_FLOOR_L));
    rd(A_STATUS, 32'h1);
    ex(cop(FMT_D, 5'h0, 5'h2, 5'h4, FN_FLOOR_L));
    rd(A_STATUS, 32'h1);
    ex(cop(5'h14, 5'h0, 5'h2, 5'h4, FN_FLOOR_W));
    rd(A_STATUS, 32'h1);
    $display("done: floor");
    put(5'h4, 32'h3F80_0001);
    for (int m = 0; m < 4; m++) begin
      wr(A_CTRL, {29'h0, m[1:0], 1'b1});
      ex(cop(FMT_S, 5'h4, 5'h4, 5'h5, FN_MUL));
      fpr(5'h5, A_FPR_LO, (m == 2) ? 32'h3F80_0003 : 32'h3F80_0002);
    end
    ex(cop(FMT_S, 5'h0, 5'h4, 5'h6, FN_MOV));
    rd(A_STATUS, 32'h0);
    fpr(5'h6, A_FPR_LO, 32'h3F80_0001);
    ex(cop(FMT_D, 5'h4, 5'h4, 5'h6, FN_MUL));
    rd(A_STATUS, 32'h1);
    ex(cop(FMT_D, 5'h0, 5'h4, 5'h6, FN_MOV));
    rd(A_STATUS, 32'h1);
    $display("done: multiply and copy");
    // paired registers from here: odd specifier is the high half
    wr(A_CTRL, 32'h0);
    b = ($urandom & 32'h0FFF_FFF0) | 32'h100;
    v = $urandom;
    wr(A_GPR, b);
    wr(A_MEM, v);
    ex({OP_FP_WORD_LOAD_OP, 5'h0, 5'h7, 16'hFFFC});
    rd(A_EADDR, b - 32'h4);
    fpr(5'h6, A_FPR_HI, v);
    fpr(5'h6, A_FPR_LO, 32'h3F80_0001);
    ex({OP_FP_WORD_LOAD_OP, 5'h0, 5'h6, 16'h0002});
    rd(A_STATUS, 32'h2);
    rd(A_EADDR, b + 32'h2);
    fpr(5'h6, A_FPR_LO, 32'h3F80_0001);
    ex({OP_FP_DOUBLEWORD_LOAD_OP, 5'h0, 5'h6, 16'h0000});
    rd(A_STATUS, 32'h1);
    rd(A_EADDR, b + 32'h2);
    fpr(5'h6, A_FPR_HI, v);
    $display("done: loads");
    w = $urandom | 32'h8000_0000;
    wr(A_GPR, w);
    ex(cop(RS_MT, 5'h0, 5'h9, 5'h0, 6'h0));
    rd(A_STATUS, 32'h100);
    ex(cop(RS_MF, 5'h0, 5'h9, 5'h0, 6'h0));
    rd(A_RES_LO, 32'h0);
    rd(A_STATUS, 32'h80);
    ex(cop(RS_MF, 5'h0, 5'h9, 5'h0, 6'h0));
    rd(A_RES_LO, w);
    rd(A_RES_HI, 32'hFFFF_FFFF);
    fpr(5'h8, A_FPR_HI, w);
    wr(A_CTRL, 32'h1);
    put(5'h9, ~w);
    fpr(5'h9, A_FPR_LO, ~w);
    ex(cop(RS_MF, 5'h0, 5'h9, 5'h0, 6'h0));
    rd(A_RES_HI, 32'h0);
    $display("done: moves");
    repeat (4) @(posedge CLOCK);
    give_verdict();
  end
endmodule

// [ffmlmd_chk.sv]
// Purpose: bus and trap checks on the fp decode block ports
// Assumes: one clock, synchronous reset, idle between transfers
// Notes:   bound into ffmlmd_top

`timescale 1ns/1ps

module ffmlmd_chk
  import ffmlmd_pkg::*;
(
  input wire logic        CLOCK,
  input wire logic        SRST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic [31:0] HWDATA,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        TRAP
);
  logic       ap_q;
  logic       cop;
  logic [4:0] fm;
  logic [5:0] fn;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (SRST);

  // ==========================================================
  // instruction word fields seen in the data phase
  assign cop = HWDATA[31:26] == OP_FP_COPROCESSOR_MAJOR_OPCODE;
  assign fm  = HWDATA[25:21];
  assign fn  = HWDATA[5:0];

  // data phase of an instruction write follows this flag
  always_ff @(posedge CLOCK) begin
    if (SRST) ap_q <= 1'b0;
    else ap_q <= HSEL && HREADY && HTRANS[1] && HWRITE
                 && HADDR[7:2] == A_INSTR[7:2];
  end

  sequence s_iw;
    HSEL && HREADY && HTRANS[1] && HWRITE && HADDR[7:2] == A_INSTR[7:2];
  endsequence
  sequence s_rd;
    HSEL && HREADY && HTRANS[1] && !HWRITE;
  endsequence

  // ==========================================================
  // bus answers
  a_ready_high: assert property (HREADYOUT)
    else $error("wait state inserted");
  a_resp_okay: assert property (!HRESP)
    else $error("error response");
  // read data only moves after a read address phase
  a_rdata_holds: assert property (
    !(HSEL && HREADY && HTRANS[1] && !HWRITE) |=> $stable(HRDATA))
    else $error("read data moved without a read");
  // trap level only moves at an instruction issue
  a_trap_holds: assert property (!ap_q |=> $stable(TRAP))
    else $error("trap moved without an instruction");

  // ==========================================================
  // decode outcomes
  a_floorl_trap: assert property (
    s_iw ##1 (cop && fn == FN_FLOOR_L && (fm == FMT_S || fm == FMT_D))
    |=> TRAP) else $error("floor to long not trapped");
  a_floor_fmt: assert property (
    s_iw ##1 (cop && fn == FN_FLOOR_W && fm inside {5'h14, 5'h15})
    |=> TRAP) else $error("floor from fixed point accepted");
  a_dword_trap: assert property (
    s_iw ##1 (HWDATA[31:26] == OP_FP_DOUBLEWORD_LOAD_OP) |=> TRAP)
    else $error("doubleword load not trapped");
  a_dbl_trap: assert property (
    s_iw ##1 (cop && fm == FMT_D && (fn == FN_MUL || fn == FN_MOV))
    |=> TRAP) else $error("double arithmetic not trapped");
  a_copy_quiet: assert property (
    s_iw ##1 (cop && fm == FMT_S && fn == FN_MOV) |=> !TRAP)
    else $error("single copy trapped");
  a_move_quiet: assert property (
    s_iw ##1 (cop && (fm == RS_MF || fm == RS_MT) && HWDATA[10:0] == 11'h0)
    |=> !TRAP) else $error("register move trapped");
endmodule

bind ffmlmd_top ffmlmd_chk u_chk (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL),
  .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HWDATA(HWDATA),
  .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .TRAP(TRAP));

// [ffmlmd_cpu_model.sv]
// Purpose: integer pipeline side, an AHB-Lite master of single words
// Assumes: one slave, its ready is the bus ready
// Notes:   released write data shows the inverse of the last word

`timescale 1ns/1ps

module ffmlmd_cpu_model (
  input  wire logic        CLOCK,
  input  wire logic [31:0] HRDATA,
  input  wire logic        HREADY,
  output logic             HSEL,
  output logic [31:0]      HADDR,
  output logic [1:0]       HTRANS,
  output logic             HWRITE,
  output logic [2:0]       HSIZE,
  output logic [31:0]      HWDATA
);
  // ==========================================================
  // idle bus at time zero
  initial begin
    HSEL   = 1'b0;
    HADDR  = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE  = 3'h2;
    HWDATA = 32'h0;
  end

  // one transfer; idle follows so phases never overlap
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge CLOCK);
    HSEL   <= 1'b1;
    HTRANS <= 2'h2;
    HWRITE <= w;
    HADDR  <= {24'h0, a};
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    HSEL   <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= d;
    do @(posedge CLOCK); while (HREADY !== 1'b1);
    q = HRDATA;
    HWDATA <= ~d;
  endtask
endmodule

// [ffmlmd_mul.sv]
// Purpose: single-precision multiply with selectable rounding
// Assumes: denormal operands and results flush to signed zero
// Notes:   purely combinational, one cycle in the caller

`timescale 1ns/1ps

module ffmlmd_mul
  import ffmlmd_pkg::*;
(
  input  wire logic [31:0] a,
  input  wire logic [31:0] b,
  input  wire logic [1:0]  rm,
  output logic      [31:0] p,
  output logic             invalid,
  output logic             overflow,
  output logic             underflow,
  output logic             inexact
);

  // ==========================================================
  // operand classes
  logic        sgn;
  logic        nan_a;
  logic        nan_b;
  logic        inf_a;
  logic        inf_b;
  logic        zro_a;
  logic        zro_b;
  logic [47:0] prod;
  logic [22:0] mant;
  logic        grd;
  logic        stk;
  logic        up;
  logic [23:0] mant_r;
  logic signed [9:0] e;

  assign sgn   = a[31] ^ b[31];
  assign nan_a = (a[30:23] == 8'hFF) && (a[22:0] != 23'h0);
  assign nan_b = (b[30:23] == 8'hFF) && (b[22:0] != 23'h0);
  assign inf_a = (a[30:23] == 8'hFF) && (a[22:0] == 23'h0);
  assign inf_b = (b[30:23] == 8'hFF) && (b[22:0] == 23'h0);
  assign zro_a = (a[30:23] == 8'h00);
  assign zro_b = (b[30:23] == 8'h00);
  assign prod  = {1'b1, a[22:0]} * {1'b1, b[22:0]};

  // exact product, then rounded once by the current mode
  always_comb begin
    e = 10'($signed({2'b0, a[30:23]}) + $signed({2'b0, b[30:23]})
        - 10'sd127);
    if (prod[47]) begin
      mant = prod[46:24];
      grd  = prod[23];
      stk  = |prod[22:0];
      e    = e + 10'sd1;
    end else begin
      mant = prod[45:23];
      grd  = prod[22];
      stk  = |prod[21:0];
    end
    unique case (rm)
      2'h0: up = grd & (stk | mant[0]);
      2'h1: up = 1'b0;
      2'h2: up = ~sgn & (grd | stk);
      2'h3: up = sgn & (grd | stk);
    endcase
    mant_r = {1'b0, mant} + {23'h0, up};
    if (mant_r[23])
      e = e + 10'sd1;
    p         = {sgn, e[7:0], mant_r[22:0]};
    invalid   = 1'b0;
    overflow  = 1'b0;
    underflow = 1'b0;
    inexact   = grd | stk;
    // special operands win over the normal path
    if (nan_a || nan_b) begin
      p       = SP_QNAN;
      invalid = (nan_a & ~a[22]) | (nan_b & ~b[22]);
      inexact = 1'b0;
    end else if ((inf_a && zro_b) || (inf_b && zro_a)) begin
      p       = SP_QNAN;
      invalid = 1'b1;
      inexact = 1'b0;
    end else if (inf_a || inf_b) begin
      p       = {sgn, SP_INF[30:0]};
      inexact = 1'b0;
    end else if (zro_a || zro_b) begin
      p       = {sgn, 31'h0};
      inexact = 1'b0;
    end else if (e >= 10'sd255) begin
      overflow = 1'b1;
      inexact  = 1'b1;
      // modes that round away from infinity clamp to max finite
      if (rm == 2'h1 || (rm == 2'h2 && sgn) || (rm == 2'h3 && !sgn))
        p = {sgn, SP_MAXF[30:0]};
      else
        p = {sgn, SP_INF[30:0]};
    end else if (e <= 10'sd0) begin
      underflow = 1'b1;
      inexact   = 1'b1;
      p         = {sgn, 31'h0};
    end
  end

endmodule

// [ffmlmd_pkg.sv]
// Purpose: shared constants and types of the fp decode block
// Assumes: 32-bit AHB-Lite register bus, single clock
// Notes:   offsets are byte addresses of aligned words

package ffmlmd_pkg;

  // ==========================================================
  // instruction encodings
  localparam logic [5:0] OP_FP_COPROCESSOR_MAJOR_OPCODE    = 6'h11;
  localparam logic [5:0] OP_FP_WORD_LOAD_OP    = 6'h31;
  localparam logic [5:0] OP_FP_DOUBLEWORD_LOAD_OP    = 6'h35;
  localparam logic [4:0] RS_MF      = 5'h00;
  localparam logic [4:0] RS_MT      = 5'h04;
  localparam logic [4:0] FMT_S      = 5'h10;
  localparam logic [4:0] FMT_D      = 5'h11;
  localparam logic [5:0] FN_MUL     = 6'h02;
  localparam logic [5:0] FN_MOV     = 6'h06;
  localparam logic [5:0] FN_FLOOR_L = 6'h0B;
  localparam logic [5:0] FN_FLOOR_W = 6'h0F;
  localparam logic [1:0] RM_FLOOR   = 2'h3;

  // ==========================================================
  // fixed result values
  localparam logic [31:0] INT_MAX = 32'h7FFF_FFFF;
  localparam logic [31:0] INT_MIN = 32'h8000_0000;
  localparam logic [31:0] SP_QNAN = 32'h7FBF_FFFF;
  localparam logic [31:0] SP_MAXF = 32'h7F7F_FFFF;
  localparam logic [31:0] SP_INF  = 32'h7F80_0000;

  // ==========================================================
  // register map
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_INSTR  = 8'h04;
  localparam logic [7:0] A_GPR    = 8'h08;
  localparam logic [7:0] A_MEM    = 8'h0C;
  localparam logic [7:0] A_STATUS = 8'h10;
  localparam logic [7:0] A_RES_LO = 8'h14;
  localparam logic [7:0] A_RES_HI = 8'h18;
  localparam logic [7:0] A_EADDR  = 8'h1C;
  localparam logic [7:0] A_FSEL   = 8'h20;
  localparam logic [7:0] A_FPR_LO = 8'h24;
  localparam logic [7:0] A_FPR_HI = 8'h28;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic       inv_en;
    logic [1:0] rounding_mode_field;
    logic       full_register_mode_bit;
  } ffmlmd_ctrl_t;

  typedef struct packed {
    logic fpr_hazard;
    logic gpr_hazard;
    logic fp_invalid;
    logic underflow;
    logic overflow;
    logic inexact;
    logic inv_trap;
    logic addr_err;
    logic unimpl;
  } ffmlmd_status_t;

  typedef struct packed {
    logic           we;
    logic           hi;
    logic [4:0]     idx;
    logic [31:0]    data;
    logic           pend;
    logic           res_set;
    logic [63:0]    res;
    logic           ea_set;
    logic [31:0]    ea;
    ffmlmd_status_t st;
  } ffmlmd_ex_t;

endpackage

// [ffmlmd_top.sv]
// Purpose: fp coprocessor decode for floor, load, move, copy, mul
// Assumes: pipeline hands operands and instructions over AHB-Lite
// Notes:   one instruction executes per write of the instr word
//
// The AHB-Lite interface to the registers and the register offsets were chosen for this implementation.

`timescale 1ns/1ps

module ffmlmd_top
  import ffmlmd_pkg::*;
(
  input  wire logic        CLOCK,
  input  wire logic        SRST,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             TRAP
);

  // ==========================================================
  // state
  ffmlmd_ctrl_t   ctrl_r;
  ffmlmd_status_t st_r;
  ffmlmd_ex_t     ex;
  logic [31:0] instr_r;
  logic [31:0] gpr_r;
  logic [31:0] mem_r;
  logic [63:0] res_r;
  logic [31:0] ea_r;
  logic [4:0]  fsel_r;
  logic [31:0] hrdata_r;
  logic        wr_r;
  logic [7:0]  wa_r;
  logic        pend_r;
  logic        pend_hi_r;
  logic [4:0]  pend_idx_r;
  logic [31:0] pend_data_r;
  logic [31:0] fpr_lo [32];
  logic [31:0] fpr_hi [32];
  logic        issue;
  logic        fr;
  logic [31:0] mul_p;
  logic        mul_inv;
  logic        mul_ovf;
  logic        mul_unf;
  logic        mul_inx;
  logic [31:0] fs32;
  logic [31:0] ft32;
  logic [5:0]  fs_tgt;

  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;
  assign HRDATA    = hrdata_r;
  assign TRAP      = st_r.unimpl | st_r.addr_err | st_r.inv_trap;
  assign fr        = ctrl_r.full_register_mode_bit;
  assign issue     = wr_r && (wa_r == A_INSTR);

  // ==========================================================
  // helpers

  // 32-bit view of a specifier: half of the even pair or low word
  function automatic logic [31:0] rd32(input logic [4:0] n);
    logic [4:0] ev;
    ev = {n[4:1], 1'b0};
    if (fr)
      rd32 = fpr_lo[n];
    else if (n[0])
      rd32 = fpr_hi[ev];
    else
      rd32 = fpr_lo[ev];
  endfunction

  function automatic logic [63:0] rd64(input logic [4:0] n);
    logic [4:0] ev;
    ev = fr ? n : {n[4:1], 1'b0};
    rd64 = {fpr_hi[ev], fpr_lo[ev]};
  endfunction

  // target of a 32-bit write: {high half, register index}
  function automatic logic [5:0] wt32(input logic [4:0] n);
    wt32 = fr ? {1'b0, n} : {n[0], n[4:1], 1'b0};
  endfunction

  // floor to signed word: {invalid, value}; denormals act as +-tiny
  function automatic logic [32:0] floor_w(input logic [63:0] v,
                                          input logic dbl);
    logic               s;
    logic [11:0]        be;
    logic [11:0]        emax;
    logic [52:0]        m;
    logic signed [11:0] e;
    logic [5:0]         sh;
    logic [52:0]        ip;
    logic               fnz;
    logic               nz;
    s    = dbl ? v[63] : v[31];
    be   = dbl ? {1'b0, v[62:52]} : {4'h0, v[30:23]};
    emax = dbl ? 12'h7FF : 12'h0FF;
    m    = dbl ? {1'b1, v[51:0]} : {1'b1, v[22:0], 29'h0};
    nz   = dbl ? (v[62:0] != 63'h0) : (v[30:0] != 31'h0);
    e    = dbl ? 12'($signed(be) - 12'sd1023)
               : 12'($signed(be) - 12'sd127);
    sh   = 6'h0;
    ip   = 53'h0;
    fnz  = 1'b0;
    if (be == emax)
      floor_w = {1'b1, INT_MAX};
    else if (be == 12'h0 || e < 12'sd0)
      floor_w = {1'b0, (s && nz) ? 32'hFFFF_FFFF : 32'h0};
    else if (e > 12'sd30) begin
      if (s && e == 12'sd31 && m[51:0] == 52'h0)
        floor_w = {1'b0, INT_MIN};
      else
        floor_w = {1'b1, INT_MAX};
    end else begin
      sh  = 6'(12'sd52 - e);
      ip  = m >> sh;
      fnz = (m & ((53'h1 << sh) - 53'h1)) != 53'h0;
      // negative values with a fraction step one further down
      if (s)
        floor_w = {1'b0, 32'(-(ip[31:0] + {31'h0, fnz}))};
      else
        floor_w = {1'b0, ip[31:0]};
    end
  endfunction

  // ==========================================================
  // single-precision multiplier

  // operand views in a process, so fp file writes are always seen
  always_comb begin
    fs32   = rd32(HWDATA[15:11]);
    ft32   = rd32(HWDATA[20:16]);
    fs_tgt = wt32(HWDATA[15:11]);
  end

  ffmlmd_mul u_mul (
    .a         (fs32),
    .b         (ft32),
    .rm        (ctrl_r.rounding_mode_field),
    .p         (mul_p),
    .invalid   (mul_inv),
    .overflow  (mul_ovf),
    .underflow (mul_unf),
    .inexact   (mul_inx)
  );

  // ==========================================================
  // decode and execute the word being written to the instr reg
  always_comb begin
    logic [5:0]  op;
    logic [4:0]  rs;
    logic [5:0]  fn;
    logic [5:0]  t;
    logic [32:0] fl;
    op = HWDATA[31:26];
    rs = HWDATA[25:21];
    fn = HWDATA[5:0];
    t  = wt32(HWDATA[10:6]);
    fl = floor_w(rs == FMT_D ? rd64(HWDATA[15:11])
                             : {32'h0, rd32(HWDATA[15:11])},
                 rs == FMT_D);
    ex = '0;
    ex.idx = t[4:0];
    ex.hi  = t[5];
    if (op == OP_FP_COPROCESSOR_MAJOR_OPCODE && rs == RS_MF) begin
      ex.res_set = 1'b1;
      ex.res = {{32{fs32[31]}},
                fs32};
      ex.st.gpr_hazard = 1'b1;
    end else if (op == OP_FP_COPROCESSOR_MAJOR_OPCODE && rs == RS_MT) begin
      ex.pend = 1'b1;
      ex.st.fpr_hazard = 1'b1;
    end else if (op == OP_FP_COPROCESSOR_MAJOR_OPCODE && (rs == FMT_S || rs == FMT_D)) begin
      unique case (fn)
        FN_FLOOR_L: ex.st.unimpl = 1'b1;
        FN_FLOOR_W: begin
          // rounding is fixed; the mode field is not consulted
          ex.data = fl[31:0];
          ex.st.fp_invalid = fl[32];
          ex.st.inv_trap   = fl[32] & ctrl_r.inv_en;
          ex.we = ~(fl[32] & ctrl_r.inv_en);
        end
        FN_MOV: begin
          if (rs == FMT_D)
            ex.st.unimpl = 1'b1;
          else begin
            ex.we   = 1'b1;
            ex.data = rd32(HWDATA[15:11]);
          end
        end
        FN_MUL: begin
          if (rs == FMT_D)
            ex.st.unimpl = 1'b1;
          else begin
            ex.data = mul_p;
            ex.st.fp_invalid = mul_inv;
            ex.st.overflow   = mul_ovf;
            ex.st.underflow  = mul_unf;
            ex.st.inexact    = mul_inx;
            ex.st.inv_trap   = mul_inv & ctrl_r.inv_en;
            ex.we = ~(mul_inv & ctrl_r.inv_en);
          end
        end
        default: ex.st.unimpl = 1'b1;
      endcase
    end else if (op == OP_FP_WORD_LOAD_OP) begin
      t = wt32(HWDATA[20:16]);
      ex.idx    = t[4:0];
      ex.hi     = t[5];
      ex.ea_set = 1'b1;
      ex.ea     = gpr_r + {{16{HWDATA[15]}}, HWDATA[15:0]};
      ex.data   = mem_r;
      if (ex.ea[1:0] != 2'h0)
        ex.st.addr_err = 1'b1;
      else
        ex.we = 1'b1;
    end else begin
      // doubleword load and anything else undecoded
      ex.st.unimpl = 1'b1;
    end
  end

  // ==========================================================
  // ahb address phase: latch write target, register read data
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      wr_r     <= 1'b0;
      wa_r     <= 8'h0;
      hrdata_r <= 32'h0;
    end else begin
      wr_r <= HSEL && HREADY && HTRANS[1] && HWRITE;
      wa_r <= {HADDR[7:2], 2'b00};
      if (HSEL && HREADY && HTRANS[1] && !HWRITE) begin
        unique case ({HADDR[7:2], 2'b00})
          A_CTRL:   hrdata_r <= {28'h0, ctrl_r};
          A_INSTR:  hrdata_r <= instr_r;
          A_GPR:    hrdata_r <= gpr_r;
          A_MEM:    hrdata_r <= mem_r;
          A_STATUS: hrdata_r <= {23'h0, st_r};
          A_RES_LO: hrdata_r <= res_r[31:0];
          A_RES_HI: hrdata_r <= res_r[63:32];
          A_EADDR:  hrdata_r <= ea_r;
          A_FSEL:   hrdata_r <= {27'h0, fsel_r};
          A_FPR_LO: hrdata_r <= fpr_lo[fsel_r];
          A_FPR_HI: hrdata_r <= fpr_hi[fsel_r];
          default:  hrdata_r <= 32'h0;
        endcase
      end
    end
  end

  // ==========================================================
  // software-written registers (data phase)
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      ctrl_r  <= CTRL_RST;
      instr_r <= 32'h0;
      gpr_r   <= 32'h0;
      mem_r   <= 32'h0;
      fsel_r  <= 5'h0;
    end else if (wr_r) begin
      unique case (wa_r)
        A_CTRL:  ctrl_r  <= HWDATA[3:0];
        A_INSTR: instr_r <= HWDATA;
        A_GPR:   gpr_r   <= HWDATA;
        A_MEM:   mem_r   <= HWDATA;
        A_FSEL:  fsel_r  <= HWDATA[4:0];
        default: ;
      endcase
    end
  end

  // ==========================================================
  // fp file: deferred move-in lands at the next issue, then the
  // current result, so the next instruction still reads old data
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      pend_r      <= 1'b0;
      pend_hi_r   <= 1'b0;
      pend_idx_r  <= 5'h0;
      pend_data_r <= 32'h0;
      for (int i = 0; i < 32; i++) begin
        fpr_lo[i] <= 32'h0;
        fpr_hi[i] <= 32'h0;
      end
    end else if (issue) begin
      if (pend_r) begin
        if (pend_hi_r)
          fpr_hi[pend_idx_r] <= pend_data_r;
        else
          fpr_lo[pend_idx_r] <= pend_data_r;
      end
      // upper word is simply left as it was in full mode
      if (ex.we) begin
        if (ex.hi)
          fpr_hi[ex.idx] <= ex.data;
        else
          fpr_lo[ex.idx] <= ex.data;
      end
      pend_r      <= ex.pend;
      pend_hi_r   <= fs_tgt[5];
      pend_idx_r  <= fs_tgt[4:0];
      pend_data_r <= gpr_r;
    end
  end

  // ==========================================================
  // status, general-register result and effective address
  always_ff @(posedge CLOCK) begin
    if (SRST) begin
      st_r  <= '0;
      res_r <= 64'h0;
      ea_r  <= 32'h0;
    end else if (issue) begin
      st_r <= ex.st;
      if (ex.res_set)
        res_r <= ex.res;
      if (ex.ea_set)
        ea_r <= ex.ea;
    end
  end

endmodule
